// >>> common/oag_pkg.sv
package oag_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 16;
	localparam int PC_W = 10;
	localparam int IO_FIELD_W = 6;
	localparam int DISP_W = 6;
	localparam int REL_W = 12;
	localparam int REG_IDX_W = 5;
	localparam logic [ADDR_W-1:0] REG_BASE = 16'h0000;
	localparam logic [ADDR_W-1:0] IO_BASE = 16'h0020;
	localparam logic [ADDR_W-1:0] SRAM_BASE = 16'h0060;
	localparam logic [ADDR_W-1:0] DATA_END = 16'h00e0;
	localparam logic [REG_IDX_W-1:0] PTR_FIRST_LO = 5'h1a;
	localparam logic [REG_IDX_W-1:0] PTR_SECOND_LO = 5'h1c;
	localparam logic [REG_IDX_W-1:0] PTR_THIRD_LO = 5'h1e;
	localparam logic [1:0] PTR_FIRST = 2'h0;
	localparam logic [1:0] PTR_SECOND = 2'h1;
	localparam logic [1:0] PTR_THIRD = 2'h2;
	localparam logic [ADDR_W-1:0] ONE16 = 16'h0001;
	localparam logic [PC_W-1:0] PC_ONE = 10'h001;
	localparam logic [PC_W-1:0] PC_RESET = 10'h000;
	localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;

	typedef enum logic [3:0]
	{
		OAG_AM_NONE = 4'h0,
		OAG_AM_REG1 = 4'h1,
		OAG_AM_REG2 = 4'h2,
		OAG_AM_IO = 4'h3,
		OAG_AM_DIRECT = 4'h4,
		OAG_AM_DISP = 4'h5,
		OAG_AM_IND = 4'h6,
		OAG_AM_PREDEC = 4'h7,
		OAG_AM_POSTINC = 4'h8,
		OAG_AM_CONST = 4'h9,
		OAG_AM_IJUMP = 4'ha,
		OAG_AM_RJUMP = 4'hb
	} oag_mode_t;

	typedef enum logic [2:0]
	{
		OAG_REGION_REG = 3'h1,
		OAG_REGION_IO = 3'h2,
		OAG_REGION_SRAM = 3'h4,
		OAG_REGION_NONE = 3'h0
	} oag_region_t;

	// decoded instruction from the core's decoder
	typedef struct packed
	{
		oag_mode_t mode;
		logic [REG_IDX_W-1:0] dst_reg;
		logic [REG_IDX_W-1:0] src_reg;
		logic [IO_FIELD_W-1:0] io_num;
		logic [DISP_W-1:0] disp;
		logic [1:0] ptr_sel;
		logic [REL_W-1:0] rel_k;
		logic [ADDR_W-1:0] direct_addr;
		logic is_store;
	} oag_instr_t;

	typedef struct packed
	{
		logic valid;
		logic write;
		oag_region_t region;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} oag_data_req_t;
endpackage : oag_pkg

// >>> hw/oag_addr_gen.sv
// What this block does
// - single-register mode reads destination register
// - two-register mode reads both, writes destination
// - I/O location from 6-bit instruction field
// - direct mode uses 16-bit second word
// - displacement: pointer picked by ptr_sel (first, second or third) plus 6 bits
// - plain indirect uses pointer unchanged
// - pre-decrement: decrement then access
// - post-increment: access then increment
// - constant load: third pointer bits 10:1 word, bit0 byte
// - indirect jump/call loads PC from third pointer
// - relative jump/call goes to PC+k+1
// - register ALU operation finishes in one cycle
// - SRAM access takes two cycles
// - 10-bit program counter, 1024 words
// - first 96 registers/I/O, next 128 SRAM
// - only lowest 224 addresses are decoded
// - runs directly on system clock
// - fetch overlaps execution, one per clock
// - pointers from registers 26 to 31
`timescale 1ns/100ps
`default_nettype none
module oag_addr_gen
#(
	parameter int NREGS = 32
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// decoded instruction in
	input wire logic instr_valid,
	input wire oag_pkg::oag_instr_t instr,
	output logic instr_ready,
	// alu interface
	output logic [oag_pkg::DATA_W-1:0] alu_a,
	output logic [oag_pkg::DATA_W-1:0] alu_b,
	input wire logic [oag_pkg::DATA_W-1:0] alu_result,
	// program memory
	output logic [oag_pkg::PC_W-1:0] fetch_addr,
	output logic [oag_pkg::PC_W-1:0] const_word_addr,
	input wire logic [2*oag_pkg::DATA_W-1:0] const_word,
	output logic [oag_pkg::DATA_W-1:0] const_byte,
	// data space
	output oag_pkg::oag_data_req_t data_req,
	output logic [oag_pkg::ADDR_W-1:0] data_local_addr,
	input wire logic [oag_pkg::DATA_W-1:0] data_rdata,
	// program counter
	output logic [oag_pkg::PC_W-1:0] pc
);
	import oag_pkg::*;

	typedef enum logic [1:0]
	{
		OAG_ST_RUN = 2'b01,
		OAG_ST_MEM = 2'b10
	} oag_state_t;

	function automatic logic [ADDR_W-1:0] oag_ptr_pick(input logic [1:0] sel,
		input logic [ADDR_W-1:0] p0, input logic [ADDR_W-1:0] p1,
		input logic [ADDR_W-1:0] p2);
		if (sel == PTR_FIRST)
			return p0;
		else if (sel == PTR_SECOND)
			return p1;
		else
			return p2;
	endfunction : oag_ptr_pick

	function automatic logic [REG_IDX_W-1:0] oag_ptr_lo(input logic [1:0] sel);
		if (sel == PTR_FIRST)
			return PTR_FIRST_LO;
		else if (sel == PTR_SECOND)
			return PTR_SECOND_LO;
		else
			return PTR_THIRD_LO;
	endfunction : oag_ptr_lo

	oag_state_t state_q, state_d;
	logic [PC_W-1:0] pc_q, pc_d;
	oag_data_req_t req_q, req_d;
	logic [REG_IDX_W-1:0] mem_dst_q, mem_dst_d;
	logic [DATA_W-1:0] cbyte_q, cbyte_d;

	logic [DATA_W-1:0] rd_a, rd_b;
	logic [ADDR_W-1:0] p_first, p_second, p_third, p_sel, ea;
	logic wr_en, ptr_wr_en;
	logic [REG_IDX_W-1:0] wr_idx;
	logic [DATA_W-1:0] wr_data;
	logic [ADDR_W-1:0] ptr_wr_val;
	oag_region_t ea_region;
	logic [ADDR_W-1:0] rel_ext;
	logic is_mem;

	oag_regfile #(.NREGS(NREGS)) u_regs
	(
		.core_clk(core_clk),
		.reset(reset),
		.rd_a_idx(instr.dst_reg),
		.rd_a_data(rd_a),
		.rd_b_idx(instr.src_reg),
		.rd_b_data(rd_b),
		.wr_en(wr_en),
		.wr_idx(wr_idx),
		.wr_data(wr_data),
		.ptr_wr_en(ptr_wr_en),
		.ptr_lo_idx(oag_ptr_lo(instr.ptr_sel)),
		.ptr_wr_val(ptr_wr_val),
		.ptr_first(p_first),
		.ptr_second(p_second),
		.ptr_third(p_third)
	);

	oag_data_map u_map
	(
		.addr(req_q.addr),
		.region(),
		.local_addr(data_local_addr)
	);

	oag_data_map u_map_ea
	(
		.addr(ea),
		.region(ea_region),
		.local_addr()
	);

	assign p_sel = oag_ptr_pick(instr.ptr_sel, p_first, p_second, p_third);
	assign rel_ext = {{(ADDR_W-REL_W){instr.rel_k[REL_W-1]}}, instr.rel_k};
	assign is_mem = instr.mode inside {OAG_AM_IO, OAG_AM_DIRECT, OAG_AM_DISP,
		OAG_AM_IND, OAG_AM_PREDEC, OAG_AM_POSTINC};

	// effective data address
	always_comb
	begin
		case (instr.mode)
			OAG_AM_IO: ea = IO_BASE + {{(ADDR_W-IO_FIELD_W){1'b0}}, instr.io_num};
			OAG_AM_DIRECT: ea = instr.direct_addr;
			OAG_AM_DISP: ea = p_sel + {{(ADDR_W-DISP_W){1'b0}}, instr.disp};
			OAG_AM_IND: ea = p_sel;
			OAG_AM_PREDEC: ea = p_sel - ONE16;
			OAG_AM_POSTINC: ea = p_sel;
			default: ea = REG_BASE;
		endcase
	end

	always_comb
	begin
		state_d = state_q;
		pc_d = pc_q;
		req_d = req_q;
		req_d.valid = 1'b0;
		mem_dst_d = mem_dst_q;
		cbyte_d = cbyte_q;
		wr_en = 1'b0;
		wr_idx = instr.dst_reg;
		wr_data = alu_result;
		ptr_wr_en = 1'b0;
		ptr_wr_val = p_sel;
		instr_ready = 1'b0;
		case (state_q)
			OAG_ST_RUN:
			begin
				instr_ready = 1'b1;
				if (instr_valid)
				begin
					pc_d = pc_q + PC_ONE;
					case (instr.mode)
						OAG_AM_REG1, OAG_AM_REG2:
							wr_en = 1'b1;
						OAG_AM_CONST:
							cbyte_d = p_third[0] ? const_word[2*DATA_W-1:DATA_W]
								: const_word[DATA_W-1:0];
						OAG_AM_IJUMP:
							pc_d = p_third[PC_W-1:0];
						OAG_AM_RJUMP:
							pc_d = pc_q + rel_ext[PC_W-1:0] + PC_ONE;
						default:
							wr_en = 1'b0;
					endcase
					if (is_mem)
					begin
						// memory ops hold the next instruction for one extra cycle
						req_d.valid = 1'b1;
						req_d.write = instr.is_store;
						req_d.region = ea_region;
						req_d.addr = ea;
						req_d.wdata = rd_a;
						mem_dst_d = instr.dst_reg;
						state_d = OAG_ST_MEM;
						if (instr.mode == OAG_AM_PREDEC)
						begin
							ptr_wr_en = 1'b1;
							ptr_wr_val = ea;
						end
						else if (instr.mode == OAG_AM_POSTINC)
						begin
							ptr_wr_en = 1'b1;
							ptr_wr_val = p_sel + ONE16;
						end
					end
				end
			end
			OAG_ST_MEM:
			begin
				// second cycle: read data lands in the register
				wr_en = ~req_q.write;
				wr_idx = mem_dst_q;
				wr_data = data_rdata;
				state_d = OAG_ST_RUN;
			end
			default:
				state_d = OAG_ST_RUN;
		endcase
	end

	// no clock divider: every rising edge of core_clk advances the core
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			state_q <= OAG_ST_RUN;
			pc_q <= PC_RESET;
			req_q <= '0;
			mem_dst_q <= '0;
			cbyte_q <= BYTE_ZERO;
		end
		else
		begin
			state_q <= state_d;
			pc_q <= pc_d;
			req_q <= req_d;
			mem_dst_q <= mem_dst_d;
			cbyte_q <= cbyte_d;
		end
	end

	assign alu_a = rd_a;
	assign alu_b = rd_b;
	assign pc = pc_q;
	assign fetch_addr = pc_q;
	assign const_word_addr = p_third[PC_W:1];
	assign const_byte = cbyte_q;
	assign data_req = req_q;
endmodule : oag_addr_gen
`default_nettype wire

// >>> hw/oag_data_map.sv
`timescale 1ns/100ps
`default_nettype none
module oag_data_map
(
	// address in
	input wire logic [oag_pkg::ADDR_W-1:0] addr,
	// decoded target
	output oag_pkg::oag_region_t region,
	output logic [oag_pkg::ADDR_W-1:0] local_addr
);
	import oag_pkg::*;

	always_comb
	begin
		if (addr < IO_BASE)
		begin
			region = OAG_REGION_REG;
			local_addr = addr - REG_BASE;
		end
		else if (addr < SRAM_BASE)
		begin
			region = OAG_REGION_IO;
			local_addr = addr - IO_BASE;
		end
		else if (addr < DATA_END)
		begin
			region = OAG_REGION_SRAM;
			local_addr = addr - SRAM_BASE;
		end
		else
		begin
			// above the map nothing answers
			region = OAG_REGION_NONE;
			local_addr = addr;
		end
	end
endmodule : oag_data_map
`default_nettype wire

// >>> hw/oag_regfile.sv
`timescale 1ns/100ps
`default_nettype none
module oag_regfile
#(
	parameter int NREGS = 32
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// two read ports
	input wire logic [oag_pkg::REG_IDX_W-1:0] rd_a_idx,
	output logic [oag_pkg::DATA_W-1:0] rd_a_data,
	input wire logic [oag_pkg::REG_IDX_W-1:0] rd_b_idx,
	output logic [oag_pkg::DATA_W-1:0] rd_b_data,
	// write ports: result plus pointer update
	input wire logic wr_en,
	input wire logic [oag_pkg::REG_IDX_W-1:0] wr_idx,
	input wire logic [oag_pkg::DATA_W-1:0] wr_data,
	input wire logic ptr_wr_en,
	input wire logic [oag_pkg::REG_IDX_W-1:0] ptr_lo_idx,
	input wire logic [oag_pkg::ADDR_W-1:0] ptr_wr_val,
	// pointer pairs out
	output logic [oag_pkg::ADDR_W-1:0] ptr_first,
	output logic [oag_pkg::ADDR_W-1:0] ptr_second,
	output logic [oag_pkg::ADDR_W-1:0] ptr_third
);
	import oag_pkg::*;

	logic [DATA_W-1:0] regs_q [NREGS];
	logic [DATA_W-1:0] regs_d [NREGS];

	always_comb
	begin
		for (int i = 0; i < NREGS; i++)
		begin
			regs_d[i] = regs_q[i];
		end
		// pointer update first so an explicit result write wins
		if (ptr_wr_en)
		begin
			regs_d[ptr_lo_idx] = ptr_wr_val[DATA_W-1:0];
			regs_d[ptr_lo_idx + 5'h01] = ptr_wr_val[ADDR_W-1:DATA_W];
		end
		if (wr_en)
		begin
			regs_d[wr_idx] = wr_data;
		end
	end

	always_ff @(posedge core_clk)
	begin
		for (int i = 0; i < NREGS; i++)
		begin
			if (reset)
				regs_q[i] <= BYTE_ZERO;
			else
				regs_q[i] <= regs_d[i];
		end
	end

	assign rd_a_data = regs_q[rd_a_idx];
	assign rd_b_data = regs_q[rd_b_idx];
	assign ptr_first = {regs_q[PTR_FIRST_LO + 5'h01], regs_q[PTR_FIRST_LO]};
	assign ptr_second = {regs_q[PTR_SECOND_LO + 5'h01], regs_q[PTR_SECOND_LO]};
	assign ptr_third = {regs_q[PTR_THIRD_LO + 5'h01], regs_q[PTR_THIRD_LO]};
endmodule : oag_regfile
`default_nettype wire

// >>> sim/oag_addr_gen_sva.sv
`timescale 1ns/100ps
`default_nettype none
module oag_addr_gen_chk
(
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// watched ports
	input wire logic instr_valid,
	input wire oag_pkg::oag_instr_t instr,
	input wire logic instr_ready,
	input wire oag_pkg::oag_data_req_t data_req,
	input wire logic [oag_pkg::ADDR_W-1:0] data_local_addr,
	input wire logic [oag_pkg::PC_W-1:0] pc
);
	import oag_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	sequence s_mem_take;
		instr_valid && instr_ready && instr.mode inside {OAG_AM_IO, OAG_AM_DIRECT,
			OAG_AM_DISP, OAG_AM_IND, OAG_AM_PREDEC, OAG_AM_POSTINC};
	endsequence
	sequence s_mem_busy;
		data_req.valid && !instr_ready ##1 instr_ready;
	endsequence
	property p_mem_two;
		s_mem_take |=> s_mem_busy;
	endproperty
	a_mem_two: assert property (p_mem_two) else $error("memory op not two cycles");
	property p_req_pulse;
		data_req.valid |=> !data_req.valid;
	endproperty
	a_req_pulse: assert property (p_req_pulse) else $error("request held too long");
	property p_none;
		data_req.valid && data_req.addr >= DATA_END |-> data_req.region == OAG_REGION_NONE;
	endproperty
	a_none: assert property (p_none) else $error("high address decoded");
	property p_sram;
		data_req.valid && data_req.addr inside {[SRAM_BASE:DATA_END-1]}
			|-> data_req.region == OAG_REGION_SRAM && data_local_addr == data_req.addr - SRAM_BASE;
	endproperty
	a_sram: assert property (p_sram) else $error("sram decode wrong");
	property p_io;
		data_req.valid && data_req.addr inside {[IO_BASE:SRAM_BASE-1]}
			|-> data_req.region == OAG_REGION_IO && data_local_addr == data_req.addr - IO_BASE;
	endproperty
	a_io: assert property (p_io) else $error("io decode wrong");
	property p_reg;
		data_req.valid && data_req.addr < IO_BASE |-> data_req.region == OAG_REGION_REG;
	endproperty
	a_reg: assert property (p_reg) else $error("register decode wrong");
	property p_rjump;
		instr_valid && instr_ready && instr.mode == OAG_AM_RJUMP
			|=> pc == $past(pc) + $past(instr.rel_k[PC_W-1:0]) + PC_ONE;
	endproperty
	a_rjump: assert property (p_rjump) else $error("relative target wrong");
	property p_step;
		instr_valid && instr_ready && instr.mode == OAG_AM_REG1 |=> pc == $past(pc) + PC_ONE;
	endproperty
	a_step: assert property (p_step) else $error("pc did not step");
	property p_reg_one;
		instr_valid && instr_ready && instr.mode == OAG_AM_REG2 |=> instr_ready;
	endproperty
	a_reg_one: assert property (p_reg_one) else $error("register op stalled");
endmodule : oag_addr_gen_chk
bind oag_addr_gen oag_addr_gen_chk u_oag_addr_gen_chk (.core_clk, .reset, .instr_valid,
	.instr, .instr_ready, .data_req, .data_local_addr, .pc);
`default_nettype wire

// >>> sim/oag_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module oag_mem_model
(
	// clock
	input wire logic core_clk,
	// program and data sides
	input wire logic [oag_pkg::PC_W-1:0] const_word_addr,
	output logic [15:0] const_word,
	input wire oag_pkg::oag_data_req_t data_req,
	output logic [7:0] data_rdata
);
	import oag_pkg::*;
	logic [7:0] last_q = 8'h00;
	// lanes differ so a wrong byte pick shows
	assign const_word = {~const_word_addr[7:0], const_word_addr[7:0]};
	// idle bus inverts, so a stale sample never matches
	assign data_rdata = data_req.valid ? data_req.addr[7:0] ^ 8'h5a : ~last_q;
	always @(posedge core_clk) last_q <= data_rdata;
endmodule : oag_mem_model
`default_nettype wire

// >>> sim/tb_oag_addr_gen.sv
`timescale 1ns/100ps
`default_nettype none
module tb_oag_addr_gen;
	import oag_pkg::*;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic instr_valid = 1'b0;
	oag_instr_t instr = '0;
	oag_instr_t x = '0;
	logic [7:0] alu_result = 8'h00;
	logic instr_ready;
	logic [7:0] alu_a, alu_b, const_byte, data_rdata;
	logic [9:0] fetch_addr, const_word_addr, pc;
	logic [15:0] const_word, data_local_addr;
	oag_data_req_t data_req;
	int error_cnt = 0;
	int cmp_count = 0;
	initial forever #10 core_clk = ~core_clk;
	oag_addr_gen u_oag_addr_gen (.core_clk, .reset, .instr_valid, .instr, .instr_ready,
		.alu_a, .alu_b, .alu_result, .fetch_addr, .const_word_addr, .const_word,
		.const_byte, .data_req, .data_local_addr, .data_rdata, .pc);
	oag_mem_model u_oag_mem_model (.core_clk, .const_word_addr, .const_word, .data_req,
		.data_rdata);
	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e)
		begin
			error_cnt++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task go(input oag_mode_t m, input logic [7:0] v);
		@(posedge core_clk);
		x.mode = m;
		instr <= x;
		instr_valid <= 1'b1;
		alu_result <= v;
		#1;
	endtask : go
	task take;
		@(posedge core_clk);
		instr_valid <= 1'b0;
		x = '0;
		#1;
	endtask : take
	task wr(input logic [4:0] d, input logic [7:0] v);
		x.dst_reg = d;
		go(OAG_AM_REG1, v);
		take;
	endtask : wr
	task rd(input logic [4:0] d, input logic [7:0] e);
		x.dst_reg = d;
		go(OAG_AM_REG1, e);
		chk("alu_a", alu_a, e);
		take;
	endtask : rd
	task setp(input logic [4:0] lo, input logic [15:0] v);
		wr(lo, v[7:0]);
		wr(lo + 5'h01, v[15:8]);
	endtask : setp
	task mem(input oag_mode_t m, input logic [15:0] a, input oag_region_t r,
		input logic [15:0] l);
		go(m, 8'h00);
		take;
		chk("valid", data_req.valid, 1'b1);
		chk("addr", data_req.addr, a);
		chk("region", data_req.region, r);
		if (r != OAG_REGION_NONE)
			chk("local", data_local_addr, l);
		chk("write", data_req.write, 1'b0);
		chk("busy", instr_ready, 1'b0);
		@(posedge core_clk);
		#1;
		chk("ready", instr_ready, 1'b1);
	endtask : mem
	task t_reg;
		wr(5'h05, 8'h3c);
		wr(5'h06, 8'ha5);
		x.dst_reg = 5'h06;
		x.src_reg = 5'h05;
		go(OAG_AM_REG2, 8'h77);
		chk("alu_a", alu_a, 8'ha5);
		chk("alu_b", alu_b, 8'h3c);
		take;
		rd(5'h06, 8'h77);
		$display("done t_reg");
	endtask : t_reg
	task t_ind;
		setp(5'h1a, 16'h0070);
		x.dst_reg = 5'h03;
		mem(OAG_AM_IND, 16'h0070, OAG_REGION_SRAM, 16'h0010);
		rd(5'h03, 8'h2a);
		mem(OAG_AM_POSTINC, 16'h0070, OAG_REGION_SRAM, 16'h0010);
		mem(OAG_AM_IND, 16'h0071, OAG_REGION_SRAM, 16'h0011);
		mem(OAG_AM_PREDEC, 16'h0070, OAG_REGION_SRAM, 16'h0010);
		setp(5'h1c, 16'h0060);
		x.ptr_sel = PTR_SECOND;
		x.disp = 6'h3f;
		mem(OAG_AM_DISP, 16'h009f, OAG_REGION_SRAM, 16'h003f);
		$display("done t_ind");
	endtask : t_ind
	task t_map;
		x.direct_addr = 16'h0015;
		mem(OAG_AM_DIRECT, 16'h0015, OAG_REGION_REG, 16'h0015);
		x.io_num = 6'h3f;
		mem(OAG_AM_IO, 16'h005f, OAG_REGION_IO, 16'h003f);
		x.direct_addr = 16'h00df;
		mem(OAG_AM_DIRECT, 16'h00df, OAG_REGION_SRAM, 16'h007f);
		x.direct_addr = 16'h00e0;
		mem(OAG_AM_DIRECT, 16'h00e0, OAG_REGION_NONE, 16'h0000);
		$display("done t_map");
	endtask : t_map
	task t_const(input logic [15:0] z, input logic [7:0] e);
		setp(5'h1e, z);
		x.dst_reg = 5'h04;
		go(OAG_AM_CONST, 8'h00);
		chk("word", const_word_addr, 10'h003);
		take;
		chk("byte", const_byte, e);
		$display("done t_const");
	endtask : t_const
	task t_jump;
		setp(5'h1e, 16'h0523);
		go(OAG_AM_IJUMP, 8'h00);
		take;
		chk("pc", pc, 10'h123);
		x.rel_k = 12'h005;
		go(OAG_AM_RJUMP, 8'h00);
		take;
		chk("pc", pc, 10'h129);
		x.rel_k = 12'hffe;
		go(OAG_AM_RJUMP, 8'h00);
		take;
		chk("pc", pc, 10'h128);
		chk("fetch", fetch_addr, 10'h128);
		$display("done t_jump");
	endtask : t_jump
	task t_store;
		x.dst_reg = 5'h05;
		x.is_store = 1'b1;
		x.direct_addr = 16'h0080;
		go(OAG_AM_DIRECT, 8'h00);
		take;
		chk("write", data_req.write, 1'b1);
		chk("wdata", data_req.wdata, 8'h3c);
		chk("addr", data_req.addr, 16'h0080);
		chk("busy", instr_ready, 1'b0);
		@(posedge core_clk);
		#1;
		// a store must leave its source register alone
		rd(5'h05, 8'h3c);
		$display("done t_store");
	endtask : t_store
	task t_reset;
		@(posedge core_clk);
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		#1;
		chk("pc", pc, 10'h000);
		chk("const", const_byte, 8'h00);
		chk("valid", data_req.valid, 1'b0);
		x.dst_reg = 5'h06;
		go(OAG_AM_NONE, 8'h00);
		chk("cleared", alu_a, 8'h00);
		take;
		chk("pc", pc, 10'h001);
		$display("done t_reset");
	endtask : t_reset
	task test_done;
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done
	initial
	begin
		repeat (8) @(posedge core_clk);
		reset <= 1'b0;
		t_reg;
		t_ind;
		t_map;
		t_const(16'h0007, 8'hfc);
		t_const(16'h0006, 8'h03);
		t_jump;
		t_store;
		t_reset;
		test_done;
	end
	// hang guard
	initial
	begin
		repeat (5000) @(posedge core_clk);
		error_cnt++;
		test_done;
	end
endmodule : tb_oag_addr_gen
`default_nettype wire
